// >>> include/ssq_pkg.sv
package ssq_pkg;

  // Startup step lengths, in edges of the clock that each step counts.
  localparam int REF_CNT_CYC = 32'h0001_0000;
  localparam int FB_CNT_CYC = 32'h0001_0000;
  localparam int CAL_CNT_CYC = 32'h0002_0000;
  // Feedback counter setting under which the feedback step is defined.
  localparam int FB_COUNT_SETTING = 32'h0000_0020;

  // Lock indication delay after the outputs turn on, in reference edges.
  localparam int LOCK_MIN_CYC = 32'h0000_0800;
  localparam int LOCK_MAX_CYC = 32'h0000_0A00;
  localparam int LOCK_CYC = 32'h0000_0901;

  // System clock cycles without a primary edge before it counts as lost.
  localparam int LOS_TIMEOUT_CYC = 32'h0000_0040;

  localparam int CNT_W = 32'h0000_0012;
  localparam int LOCK_W = 32'h0000_000C;
  localparam int LOS_W = 32'h0000_0010;
  localparam int PIN_W = 32'h0000_0008;

  typedef enum logic [2:0] {SQ_HOLD, SQ_REF, SQ_FB, SQ_CAL, SQ_RUN} ssq_seq_t;
  typedef enum logic [1:0] {MX_RUN, MX_PARK, MX_WAIT} ssq_mux_st_t;

  // Raw device pins, all outside the system clock domain.
  typedef struct packed {
    logic amp_ok;
    logic feedback_divided_clock;
    logic secondary_reference_input;
    logic primary_reference_input;
    logic ref_select_pin;
    logic interface_mode_pin;
    logic power_down_pin_b;
    logic active_low_reset_pin;
  } ssq_pins_t;

  // Reference selection configuration, held by the register bank.
  typedef struct packed {
    logic mux_manual_mode_bit;
    logic mux_pin_control_bit;
    logic pin_mode_auto;
  } ssq_mux_cfg_t;

endpackage : ssq_pkg

// >>> hdl/ssq_sync.sv
`timescale 1ns/10ps
module ssq_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // Only the second stage is visible outside this module.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule : ssq_sync

// >>> hdl/ssq_refmux.sv
`timescale 1ns/10ps
module ssq_refmux
  import ssq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pri_lvl,
  input wire logic sec_lvl,
  input wire logic want_sec,
  output logic sel_sec,
  output logic ref_out
);

  ssq_mux_st_t st_r, st_nxt;
  logic sel_r, sel_nxt;
  logic ref_out_r, ref_out_nxt;
  logic cur_lvl;
  logic new_lvl;
  logic new_prev_r;

  // A switch first lets the old source finish its high phase, then waits for
  // the new source to fall, so neither a high nor a low phase is cut short.
  always_comb begin
    st_nxt = st_r;
    sel_nxt = sel_r;
    cur_lvl = sel_r ? sec_lvl : pri_lvl;
    new_lvl = sel_r ? pri_lvl : sec_lvl;
    ref_out_nxt = 1'b0;
    unique case (st_r)
      MX_RUN: begin
        ref_out_nxt = cur_lvl;
        if (want_sec != sel_r) begin
          st_nxt = MX_PARK;
        end
      end
      MX_PARK: begin
        ref_out_nxt = cur_lvl;
        if (!cur_lvl) begin
          st_nxt = MX_WAIT;
        end
      end
      MX_WAIT: begin
        if (want_sec == sel_r) begin
          if (!cur_lvl) begin
            st_nxt = MX_RUN;
          end
        end else if (!new_lvl && new_prev_r) begin
          sel_nxt = want_sec;
          st_nxt = MX_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= MX_RUN;
      sel_r <= 1'b0;
      ref_out_r <= 1'b0;
      new_prev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      ref_out_r <= ref_out_nxt;
      new_prev_r <= new_lvl;
    end
  end

  assign sel_sec = sel_r;
  assign ref_out = ref_out_r;

  wait_quiet_a:
    assert property (@(posedge clk) disable iff (!rst_b) (st_r == MX_WAIT) |=> !ref_out_r)
    else $error("Mux output moved while waiting for the new source.");

  switch_low_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      $changed(sel_r) |-> !ref_out_r && !$past(ref_out_r))
    else $error("Mux source changed while its output was high.");

endmodule : ssq_refmux

// >>> hdl/ssq_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - After reset release, count 64k reference edges before any later step.
// - Then count 64k feedback clock edges, counter setting 32, before calibration.
// - Calibration follows and lasts exactly 128k reference edges.
// - Outputs stay off through counting and calibration, on right after it.
// - Lock on a routed status output rises 2048 to 2560 edges after outputs on.
// - Reference mux switches automatically or manually, by pin or register bits.
// - Reference switching never produces a glitch at the mux output.
// - Register mode, manual bit clear: automatic, primary preferred, select inputs ignored.
// - Register mode, manual set, pin control clear: primary, whatever the pin.
// - Manual and pin control set: select pin low primary, high secondary.
// - Pin mode: pin low primary-or-auto, high secondary-or-auto, per configuration.
// - After a switch the output phase moves gradually, never steps; the mux only passes whole pulses, the loop's slew is not modelled here.
// - Held in reset, all clock outputs stay disabled.
// - With a crystal, stay in reset until amplitude is sufficient.
// - Reset bit high then low reruns startup and keeps current settings.
module ssq_top
  import ssq_pkg::*;
#(
  parameter int REF_CYC = REF_CNT_CYC,
  parameter int FB_CYC = FB_CNT_CYC,
  parameter int CAL_CYC = CAL_CNT_CYC,
  parameter int LOS_CYC = LOS_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ssq_pins_t pins,
  input wire ssq_mux_cfg_t mux_cfg,
  input wire logic reset_bit,
  input wire logic xtal_used,
  input wire logic status_output_zero_lock_sel,
  input wire logic status_output_one_lock_sel,
  output logic clk_out_enable,
  output logic vco_calibrating,
  output logic pll_lock,
  output logic status_output_zero,
  output logic status_output_one,
  output logic ref_select_sec,
  output logic pfd_ref,
  output logic defaults_load
);

  function automatic logic step_done(input logic [CNT_W-1:0] cnt, input int n);
    return cnt == CNT_W'(n - 1);
  endfunction : step_done

  function automatic logic pick_sec(
    input logic mode_pin,
    input ssq_mux_cfg_t cfg,
    input logic sel_pin,
    input logic pri_alive
  );
    logic r;
    r = !pri_alive;
    if (mode_pin) begin
      r = cfg.pin_mode_auto ? !pri_alive : sel_pin;
    end else if (!cfg.mux_manual_mode_bit) begin
      r = !pri_alive;
    end else if (!cfg.mux_pin_control_bit) begin
      r = 1'b0;
    end else begin
      r = sel_pin;
    end
    return r;
  endfunction : pick_sec

  ssq_pins_t pins_s;
  logic hold;
  logic pin_ok;
  logic want_sec;
  logic ref_lvl;
  logic ref_rise;
  logic fb_rise;
  logic pri_rise;

  ssq_seq_t seq_r, seq_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [LOCK_W-1:0] lock_cnt_r, lock_cnt_nxt;
  logic lock_r, lock_nxt;

  logic [LOS_W-1:0] los_cnt_r, los_cnt_nxt;
  logic pri_alive_r, pri_alive_nxt;
  logic ref_prev_r, fb_prev_r, pri_prev_r;
  logic pin_ok_prev_r;

  logic oe_r, oe_nxt;
  logic cal_r, cal_nxt;
  logic stat0_r, stat0_nxt;
  logic stat1_r, stat1_nxt;
  logic dflt_r, dflt_nxt;

  // Every pin, reference clocks included, is sampled before use; the
  // references are therefore limited to well under half the system clock.
  ssq_sync #(
    .W(PIN_W)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(pins),
    .q(pins_s)
  );

  // mode pin, register bits and select pin.
  assign want_sec = pick_sec(pins_s.interface_mode_pin, mux_cfg, pins_s.ref_select_pin,
                             pri_alive_r);

  // no output phase step.
  // The mux only hands whole pulses to the loop; the gradual phase slew
  // itself is the loop's job and is not modelled here.
  ssq_refmux u_mux (
    .clk(clk),
    .rst_b(rst_b),
    .pri_lvl(pins_s.primary_reference_input),
    .sec_lvl(pins_s.secondary_reference_input),
    .want_sec(want_sec),
    .sel_sec(ref_select_sec),
    .ref_out(ref_lvl)
  );

  assign pin_ok = pins_s.active_low_reset_pin & pins_s.power_down_pin_b;
  assign hold = !pin_ok | reset_bit | (xtal_used & !pins_s.amp_ok);
  assign ref_rise = ref_lvl & !ref_prev_r;
  assign fb_rise = pins_s.feedback_divided_clock & !fb_prev_r;
  assign pri_rise = pins_s.primary_reference_input & !pri_prev_r;

  always_comb begin
    seq_nxt = seq_r;
    cnt_nxt = cnt_r;
    lock_cnt_nxt = lock_cnt_r;
    lock_nxt = lock_r;
    if (hold) begin
      seq_nxt = SQ_HOLD;
      cnt_nxt = '0;
      lock_cnt_nxt = '0;
      lock_nxt = 1'b0;
    end else begin
      unique case (seq_r)
        SQ_HOLD: begin
          seq_nxt = SQ_REF;
          cnt_nxt = '0;
        end
        SQ_REF: begin
          if (ref_rise) begin
            if (step_done(cnt_r, REF_CYC)) begin
              seq_nxt = SQ_FB;
              cnt_nxt = '0;
            end else begin
              cnt_nxt = cnt_r + 1'b1;
            end
          end
        end
        SQ_FB: begin
          if (fb_rise) begin
            if (step_done(cnt_r, FB_CYC)) begin
              seq_nxt = SQ_CAL;
              cnt_nxt = '0;
            end else begin
              cnt_nxt = cnt_r + 1'b1;
            end
          end
        end
        SQ_CAL: begin
          if (ref_rise) begin
            if (step_done(cnt_r, CAL_CYC)) begin
              seq_nxt = SQ_RUN;
              cnt_nxt = '0;
            end else begin
              cnt_nxt = cnt_r + 1'b1;
            end
          end
        end
        SQ_RUN: begin
          if (ref_rise && !lock_r) begin
            if (lock_cnt_r == LOCK_W'(LOCK_CYC - 1)) begin
              lock_nxt = 1'b1;
            end else begin
              lock_cnt_nxt = lock_cnt_r + 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_r <= SQ_HOLD;
      cnt_r <= '0;
      lock_cnt_r <= '0;
      lock_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      cnt_r <= cnt_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      lock_r <= lock_nxt;
    end
  end

  // A lost primary is judged on the system clock, so the automatic mode
  // assumes the divided primary runs well above the timeout rate.
  always_comb begin
    los_cnt_nxt = los_cnt_r;
    if (pri_rise) begin
      los_cnt_nxt = '0;
    end else if (los_cnt_r != LOS_W'(LOS_CYC)) begin
      los_cnt_nxt = los_cnt_r + 1'b1;
    end
    pri_alive_nxt = los_cnt_nxt != LOS_W'(LOS_CYC);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      los_cnt_r <= '0;
      pri_alive_r <= 1'b1;
      ref_prev_r <= 1'b0;
      fb_prev_r <= 1'b0;
      pri_prev_r <= 1'b0;
    end else begin
      los_cnt_r <= los_cnt_nxt;
      pri_alive_r <= pri_alive_nxt;
      ref_prev_r <= ref_lvl;
      fb_prev_r <= pins_s.feedback_divided_clock;
      pri_prev_r <= pins_s.primary_reference_input;
    end
  end

  always_comb begin
    oe_nxt = seq_nxt == SQ_RUN;
    cal_nxt = seq_nxt == SQ_CAL;
    stat0_nxt = status_output_zero_lock_sel & lock_nxt;
    stat1_nxt = status_output_one_lock_sel & lock_nxt;
    dflt_nxt = pin_ok & !pin_ok_prev_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_r <= 1'b0;
      cal_r <= 1'b0;
      stat0_r <= 1'b0;
      stat1_r <= 1'b0;
      dflt_r <= 1'b0;
      pin_ok_prev_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
      cal_r <= cal_nxt;
      stat0_r <= stat0_nxt;
      stat1_r <= stat1_nxt;
      dflt_r <= dflt_nxt;
      pin_ok_prev_r <= pin_ok;
    end
  end

  assign clk_out_enable = oe_r;
  assign vco_calibrating = cal_r;
  assign pll_lock = lock_r;
  assign status_output_zero = stat0_r;
  assign status_output_one = stat1_r;
  assign pfd_ref = ref_lvl;
  assign defaults_load = dflt_r;

  // Helper counts for the checks below; nothing in the design reads them.
  int edges_h;
  int run_edges_h;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edges_h <= 0;
      run_edges_h <= 0;
    end else begin
      if (seq_nxt != seq_r) begin
        edges_h <= 0;
      end else if ((seq_r == SQ_FB) ? fb_rise : ref_rise) begin
        edges_h <= edges_h + 1;
      end
      if (seq_r != SQ_RUN) begin
        run_edges_h <= 0;
      end else if (ref_rise) begin
        run_edges_h <= run_edges_h + 1;
      end
    end
  end

  ref_count_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r == SQ_FB && $past(seq_r) == SQ_REF) |-> $past(edges_h) == REF_CYC - 1)
    else $error("Reference step left after the wrong edge count.");

  fb_count_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r == SQ_CAL && $past(seq_r) == SQ_FB) |-> $past(edges_h) == FB_CYC - 1)
    else $error("Feedback step left after the wrong edge count.");

  cal_count_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r == SQ_RUN && $past(seq_r) == SQ_CAL) |-> $past(edges_h) == CAL_CYC - 1)
    else $error("Calibration did not last the exact edge count.");

  outputs_on_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r == SQ_CAL && seq_nxt == SQ_RUN) |=> clk_out_enable && !vco_calibrating)
    else $error("Outputs not enabled right after calibration.");

  outputs_off_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      (seq_r != SQ_RUN) |-> !clk_out_enable && !pll_lock)
    else $error("Outputs or lock active outside the running state.");

  lock_window_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      $rose(pll_lock) |-> run_edges_h >= LOCK_MIN_CYC && run_edges_h <= LOCK_MAX_CYC)
    else $error("Lock rose outside its delay window.");

  abort_seq_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      hold |=> seq_r == SQ_HOLD ##1 !clk_out_enable && !status_output_zero)
    else $error("Sequence not abandoned on reset or power-down.");

  auto_pri_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      (!pins_s.interface_mode_pin && !mux_cfg.mux_manual_mode_bit && pri_alive_r)
      |-> !want_sec)
    else $error("Automatic mode left a live primary.");

  forced_pri_a:
    assert property (@(posedge clk) disable iff (!rst_b)
      (!pins_s.interface_mode_pin && mux_cfg.mux_manual_mode_bit
       && !mux_cfg.mux_pin_control_bit) |-> !want_sec)
    else $error("Forced primary selection not honoured.");

endmodule : ssq_top

// >>> sim/ssq_ref_src.sv
`timescale 1ns/10ps
module ssq_ref_src #(
  parameter int PRI_HALF = 5,
  parameter int SEC_HALF = 6,
  parameter int FB_HALF = 5
) (
  input wire logic clk,
  input wire logic pri_en,
  input wire logic sec_en,
  output logic pri_clk,
  output logic sec_clk,
  output logic fb_clk
);
  int pc = 0;
  int sc = 0;
  int fc = 0;
  initial begin
    pri_clk = 1'b0;
    sec_clk = 1'b0;
    fb_clk = 1'b0;
  end
  // secondary within 20 percent.
  // A stopped source ends its high phase and then rests low, as a lost reference
  // would; cutting a pulse short here would fake a glitch at the mux output.
  always @(negedge clk) begin
    pc = (pri_en || pri_clk) ? (pc + 1) % PRI_HALF : 0;
    sc = (sec_en || sec_clk) ? (sc + 1) % SEC_HALF : 0;
    fc = (fc + 1) % FB_HALF;
    pri_clk <= (pc == 0 && (pri_en || pri_clk)) ? ~pri_clk : pri_clk;
    sec_clk <= (sc == 0 && (sec_en || sec_clk)) ? ~sec_clk : sec_clk;
    fb_clk <= (fc == 0) ? ~fb_clk : fb_clk;
  end
endmodule : ssq_ref_src

// >>> sim/ssq_top_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    n_fail++; \
  end \
end
module ssq_top_bench;
  import ssq_pkg::*;
  localparam int RC = 8;
  localparam int FC = 8;
  localparam int CC = 16;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic amp_ok = 1'b0;
  logic sel_pin = 1'b0;
  logic mode_pin = 1'b0;
  logic pdn_b = 1'b1;
  logic rst_pin = 1'b1;
  logic pri_en = 1'b1;
  logic reset_bit = 1'b0;
  logic xtal_used = 1'b1;
  logic s0_sel = 1'b1;
  logic s1_sel = 1'b0;
  ssq_mux_cfg_t cfg = 3'b000;
  wire pri_clk;
  wire sec_clk;
  wire fb_clk;
  ssq_pins_t pins;
  logic clk_out_enable, vco_calibrating, pll_lock, st0, st1, ref_sel, pfd_ref, dl;
  int compares = 0;
  int n_fail = 0;
  int pfd_edges = 0;
  int n_dl = 0;
  int run = 0;
  int min_run = 1000;
  bit seen = 0;
  logic pfd_q = 1'b0;
  int e0, d, n0;
  logic [5:0] mux_tab [7] = '{6'b001010, 6'b010010, 6'b011011, 6'b011000,
                              6'b110011, 6'b100000, 6'b100110};
  assign pins = {amp_ok, fb_clk, sec_clk, pri_clk, sel_pin, mode_pin, pdn_b, rst_pin};
  initial begin
    forever #10 clk = ~clk;
  end
  ssq_ref_src src (.clk(clk), .pri_en(pri_en), .sec_en(1'b1), .pri_clk(pri_clk),
    .sec_clk(sec_clk), .fb_clk(fb_clk));
  ssq_top #(.REF_CYC(RC), .FB_CYC(FC), .CAL_CYC(CC), .LOS_CYC(64)) uut (.clk(clk),
    .rst_b(rst_b), .pins(pins), .mux_cfg(cfg), .reset_bit(reset_bit),
    .xtal_used(xtal_used), .status_output_zero_lock_sel(s0_sel), .status_output_one_lock_sel(s1_sel),
    .clk_out_enable(clk_out_enable), .vco_calibrating(vco_calibrating),
    .pll_lock(pll_lock), .status_output_zero(st0), .status_output_one(st1),
    .ref_select_sec(ref_sel), .pfd_ref(pfd_ref), .defaults_load(dl));
  // Run lengths of the muxed reference expose any runt pulse.
  always @(posedge clk) begin
    if (rst_b) begin
      if (pfd_ref !== pfd_q) begin
        if (pfd_ref === 1'b1) pfd_edges++;
        if (seen && run < min_run) min_run = run;
        seen = 1;
        run = 1;
      end else begin
        run++;
      end
      pfd_q = pfd_ref;
      if (dl === 1'b1) n_dl++;
    end
  end
  function automatic logic pick(input int s);
    case (s)
      0: return vco_calibrating;
      1: return clk_out_enable;
      2: return pll_lock;
      default: return ref_sel;
    endcase
  endfunction : pick
  task automatic wait_for(input int s, input logic v, input int lim);
    int i;
    i = 0;
    while (pick(s) !== v && i < lim) begin
      @(negedge clk);
      i++;
    end
    `CHK(pick(s), v)
  endtask : wait_for
  task automatic tally_and_finish;
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(negedge clk);
    `CHK({clk_out_enable, pll_lock}, 2'b00)
    rst_b = 1'b1;
    repeat (300) @(negedge clk);
    `CHK(vco_calibrating, 1'b0)
    amp_ok = 1'b1;
    e0 = pfd_edges;
    wait_for(0, 1'b1, 2000);
    d = pfd_edges - e0;
    `CHK(d >= RC + FC - 1 && d <= RC + FC + 2, 1'b1)
    `CHK(clk_out_enable, 1'b0)
    e0 = pfd_edges;
    wait_for(1, 1'b1, 1000);
    `CHK(pfd_edges - e0, CC)
    `CHK(vco_calibrating, 1'b0)
    e0 = pfd_edges;
    wait_for(2, 1'b1, 30000);
    d = pfd_edges - e0;
    `CHK(d >= 2048 && d <= 2560, 1'b1)
    `CHK({st0, st1}, 2'b10)
    $display("Test startup done");
    n0 = n_dl;
    reset_bit = 1'b1;
    repeat (3) @(negedge clk);
    `CHK({clk_out_enable, pll_lock, st0}, 3'b000)
    reset_bit = 1'b0;
    wait_for(0, 1'b1, 2000);
    `CHK(n_dl, n0)
    pdn_b = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({vco_calibrating, clk_out_enable}, 2'b00)
    pdn_b = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(n_dl, n0 + 1)
    wait_for(1, 1'b1, 3000);
    rst_pin = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(clk_out_enable, 1'b0)
    rst_pin = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(n_dl, n0 + 2)
    $display("Test abort done");
    foreach (mux_tab[k]) begin
      {mode_pin, cfg, sel_pin} = mux_tab[k][5:1];
      repeat (150) @(negedge clk);
      `CHK(ref_sel, mux_tab[k][0])
    end
    {mode_pin, cfg, sel_pin} = 5'b00001;
    repeat (150) @(negedge clk);
    pri_en = 1'b0;
    wait_for(3, 1'b1, 400);
    pri_en = 1'b1;
    wait_for(3, 1'b0, 400);
    repeat (50) @(negedge clk);
    `CHK(min_run >= 5, 1'b1)
    $display("Test mux done");
    tally_and_finish;
  end
endmodule : ssq_top_bench
